// *** testbench/ccpu_compare_pwm_unit_test.sv ***
// self-checking bench for the compare and pwm unit
`timescale 1ns/1ps
`default_nettype none
module ccpu_compare_pwm_unit_test import ccpu_pkg::*;;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic [7:0] s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0, sleep_i = 1'h0;
    logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, tb_clk_i, adc_en_i, adc_start_o;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, module_pin_o, module_pin_oe_n_o, special_trig_o, pad;
    logic [1:0] bq[$];   // expected write responses
    logic [33:0] rq[$];  // expected {resp, data} of reads
    logic [33:0] e;
    logic [3:0] modes [5] = '{CCPU_M_TOGGLE, CCPU_M_SET, CCPU_M_CLEAR, CCPU_M_SWI, CCPU_M_SPECIAL};
    int errors = 0, checks = 0, cyc = 0, adcs = 0, c, hi, df;
    always #4 clk_i = ~clk_i;
    ccpu_top u_dut (.*);
    ccpu_far_side u_far (.clk_i(clk_i), .pin_i(module_pin_o), .oe_n_i(module_pin_oe_n_o),
        .tb_clk_o(tb_clk_i), .adc_en_o(adc_en_i), .pad_o(pad));
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            errors++;
            $display("ERROR %0t got %h want %h", $time, g, x);
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // answers judged at mid-cycle, away from the sampling edge
    always @(negedge clk_i) begin
        if (s_axi_bvalid_o && s_axi_bready_i) chk(s_axi_bresp_o, bq.pop_front());
        if (s_axi_rvalid_o && s_axi_rready_i) begin
            e = rq.pop_front();
            chk({s_axi_rresp_o, s_axi_rdata_o}, e);
        end
        if (adc_start_o) adcs++;
    end
    // hang guard, far above the 1500 or so cycles needed
    always @(posedge clk_i) if (++cyc > 30000) begin
        errors++;
        print_verdict();
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta = 1'h0, tw = 1'h0;
        @(posedge clk_i);
        bq.push_back(r);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'h1;
        s_axi_wvalid_i <= 1'h1;
        s_axi_bready_i <= 1'h1;
        do begin
            @(negedge clk_i);
            ta |= s_axi_awready_o;
            tw |= s_axi_wready_o;
            @(posedge clk_i);
            if (ta) s_axi_awvalid_i <= 1'h0;
            if (tw) s_axi_wvalid_i <= 1'h0;
        end while (!(ta && tw));
        do @(negedge clk_i); while (!s_axi_bvalid_o);
        @(posedge clk_i);
        s_axi_bready_i <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk_i);
        rq.push_back({r, d});
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'h1;
        s_axi_rready_i <= 1'h1;
        do @(negedge clk_i); while (!s_axi_arready_o);
        @(posedge clk_i);
        s_axi_arvalid_i <= 1'h0;
        do @(negedge clk_i); while (!s_axi_rvalid_o);
        @(posedge clk_i);
        s_axi_rready_i <= 1'h0;
    endtask
    initial begin
        void'($urandom(73));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        rd(CCPU_CTRL0, 32'h40, 2'h0);
        rd(CCPU_PWMCFG, 32'hFF, 2'h0);
        rd(8'h30, 32'h0, CCPU_RESP_SLVERR);
        wr(8'h30, 32'h1, CCPU_RESP_SLVERR);
        // every compare action on both modules, random match point
        for (int m = 0; m < 2; m++) for (int k = 0; k < 5; k++) begin
            c = 2 + $urandom % 4;
            wr(CCPU_TBASE, 32'h0, 2'h0);
            wr(8'(CCPU_CMP0 + 4 * m), c, 2'h0);
            wr(8'(4 * m), {28'h0, modes[k]}, 2'h0);
            wr(CCPU_FLAGS, 32'hF, 2'h0);
            u_far.pulse(c + 2);
            rd(CCPU_FLAGS, 32'h1 << m, 2'h0);
            rd(CCPU_TBASE, (k == 4) ? 1 : c + 2, 2'h0);
            if (k < 3) chk(pad[m], k < 2);
            wr(8'(4 * m), 32'h0, 2'h0);
            repeat (2) @(negedge clk_i);
            chk(pad[m], 0);
            rd(CCPU_STATUS, 32'hA0D, 2'h0);
        end
        chk(adcs, 1);
        // match withdrawn before the next tick
        wr(CCPU_TBASE, 32'h0, 2'h0);
        wr(CCPU_CTRL0, {28'h0, CCPU_M_SPECIAL}, 2'h0);
        wr(CCPU_CMP0, 32'h3, 2'h0);
        u_far.pulse(3);
        wr(CCPU_CMP0, 32'h100, 2'h0);
        u_far.pulse(2);
        rd(CCPU_TBASE, 32'h5, 2'h0);
        sleep_i <= 1'h1;
        u_far.pulse(3);
        rd(CCPU_TBASE, 32'h5, 2'h0);
        sleep_i <= 1'h0;
        // driver off, period, mode, duty, flag, start, then drive
        wr(CCPU_CTRL0, 32'h40, 2'h0);
        wr(CCPU_PWMCFG, 32'h3, 2'h0);
        wr(CCPU_CTRL0, 32'h4C, 2'h0);
        wr(CCPU_CTRL1, 32'h4C, 2'h0);
        wr(CCPU_DUTY0, 32'h1, 2'h0);
        wr(CCPU_DUTY1, 32'h1, 2'h0);
        wr(CCPU_FLAGS, 32'h4, 2'h0);
        wr(CCPU_PWMCFG, 32'h403, 2'h0);
        repeat (40) @(posedge clk_i);
        rd(CCPU_FLAGS, 32'h7, 2'h0);
        wr(CCPU_CTRL0, 32'hC, 2'h0);
        wr(CCPU_CTRL1, 32'hC, 2'h0);
        hi = 0;
        df = 0;
        repeat (64) @(negedge clk_i) begin
            hi += pad[0];
            df += (pad[0] !== pad[1]);
        end
        chk(hi, 16);
        chk(df, 0);
        wr(CCPU_DUTY0, 32'hFF, 2'h0);
        repeat (40) @(negedge clk_i);
        df = 0;
        hi = pad[0];
        repeat (64) @(negedge clk_i) df += (pad[0] !== module_pin_o[0] || pad[0] !== hi[0]);
        chk(df, 0);
        print_verdict();
    end
endmodule
`default_nettype wire

// *** testbench/ccpu_far_side.sv ***
// far side: timebase clock source, adc enable, pin load
`timescale 1ns/1ps
`default_nettype none
module ccpu_far_side (
    input wire logic clk_i,
    input wire logic [1:0] pin_i,
    input wire logic [1:0] oe_n_i,
    output logic tb_clk_o,
    output logic adc_en_o,
    output wire logic [1:0] pad_o
);
    // released pad falls to the pull-down
    assign pad_o = pin_i & ~oe_n_i;
    initial begin
        tb_clk_o = 1'h0;
        adc_en_o = 1'h1;
    end
    // slow edges well below sysclk, idle low between bursts
    task automatic pulse(input int n);
        repeat (n) begin
            repeat (5) @(posedge clk_i);
            tb_clk_o <= 1'h1;
            repeat (5) @(posedge clk_i);
            tb_clk_o <= 1'h0;
        end
        repeat (8) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// *** testbench/ccpu_top_assertions.sv ***
// port-level checks on the compare and pwm unit
`timescale 1ns/1ps
`default_nettype none
module ccpu_top_assertions import ccpu_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic sleep_i,
    input wire logic [1:0] module_pin_o,
    input wire logic [1:0] module_pin_oe_n_o,
    input wire logic [1:0] special_trig_o,
    input wire logic adc_start_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // both halves of a write taken at one edge
    sequence wr_take; s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o; endsequence
    // five cycles covers the sleep synchroniser delay
    sequence asleep; sleep_i [*5]; endsequence
    trig_pulse_a: assert property (special_trig_o[0] |=> !special_trig_o[0]) else $error("trigger held");
    adc_trig_a: assert property (adc_start_o |-> special_trig_o[1]) else $error("adc start alone");
    rst_oe_a: assert property ($fell(rst_i) |-> module_pin_oe_n_o == 2'h3) else $error("pins not input");
    b_after_w_a: assert property (wr_take |-> ##2 s_axi_bvalid_o) else $error("no write answer");
    b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o) else $error("bvalid dropped");
    r_after_ar_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o) else $error("no read");
    one_write_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o) else $error("overlap");
    sleep_hold_a: assert property (asleep |-> $stable(module_pin_o)) else $error("pin moved asleep");
endmodule
bind ccpu_top ccpu_top_assertions u_chk (.*);
`default_nettype wire

// *** verilog/ccpu_cmp_timebase.sv ***
// 16-bit compare timebase with overflow pulse and clear-on-tick
`timescale 1ns/1ps
`default_nettype none
module ccpu_cmp_timebase import ccpu_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,        // one-cycle timebase clock edge
    input wire logic freeze_i,      // sleep: hold everything
    input wire logic clear_i,       // special event reset, qualified at tick
    input wire logic wr_i,          // software load
    input wire logic [15:0] wr_data_i,
    output logic [15:0] count_o,
    output logic ovf_o              // one-cycle overflow pulse
);
    ccpu_tb_st_t st_q, st_d;

    // next state
    always_comb begin
        st_d = st_q;
        st_d.ovf = 1'b0;
        if (freeze_i) begin
            st_d = st_q;            // held while asleep, no pulse repeats
            st_d.ovf = 1'b0;
        end else if (wr_i) begin
            st_d.count = wr_data_i;
        end else if (tick_i) begin
            if (clear_i) begin
                st_d.count = CCPU_CMP_RST;
            end else begin
                st_d.count = st_q.count + 16'h0001;
                st_d.ovf = (st_q.count == 16'hFFFF);
            end
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count_o = st_q.count;
    assign ovf_o = st_q.ovf;
endmodule
`default_nettype wire

// *** verilog/ccpu_pkg.sv ***
// shared constants and carrier types for the compare / pwm unit
package ccpu_pkg;
    // register byte offsets on the axi4-lite slave
    localparam logic [7:0] CCPU_CTRL0 = 8'h00;
    localparam logic [7:0] CCPU_CTRL1 = 8'h04;
    localparam logic [7:0] CCPU_CMP0 = 8'h08;
    localparam logic [7:0] CCPU_CMP1 = 8'h0C;
    localparam logic [7:0] CCPU_DUTY0 = 8'h10;
    localparam logic [7:0] CCPU_DUTY1 = 8'h14;
    localparam logic [7:0] CCPU_TBASE = 8'h18;
    localparam logic [7:0] CCPU_PWMCFG = 8'h1C;
    localparam logic [7:0] CCPU_PWMTB = 8'h20;
    localparam logic [7:0] CCPU_FLAGS = 8'h24;
    localparam logic [7:0] CCPU_STATUS = 8'h28;
    // mode select field encodings
    localparam logic [3:0] CCPU_M_OFF = 4'h0;
    localparam logic [3:0] CCPU_M_TOGGLE = 4'h2;
    localparam logic [3:0] CCPU_M_SET = 4'h8;
    localparam logic [3:0] CCPU_M_CLEAR = 4'h9;
    localparam logic [3:0] CCPU_M_SWI = 4'hA;
    localparam logic [3:0] CCPU_M_SPECIAL = 4'hB;
    localparam logic [1:0] CCPU_M_PWM_TOP = 2'h3;
    // flag register bit positions
    localparam int CCPU_F_EVT0 = 0;
    localparam int CCPU_F_EVT1 = 1;
    localparam int CCPU_F_PERIOD = 2;
    localparam int CCPU_F_OVF = 3;
    // pwm config field positions
    localparam int CCPU_PC_PRESC = 8;
    localparam int CCPU_PC_ON = 10;
    // prescale limits (1, 4, 16) minus one
    localparam logic [3:0] CCPU_PS1 = 4'h0;
    localparam logic [3:0] CCPU_PS4 = 4'h3;
    localparam logic [3:0] CCPU_PS16 = 4'hF;
    // extra low bits of the extended pwm count
    localparam int CCPU_PWM_EXT = 2;
    // axi responses
    localparam logic [1:0] CCPU_RESP_OK = 2'h0;
    localparam logic [1:0] CCPU_RESP_SLVERR = 2'h2;
    // reset values
    localparam logic [15:0] CCPU_CMP_RST = 16'h0000;
    localparam logic [7:0] CCPU_PERIOD_RST = 8'hFF;

    // one module control register
    typedef struct packed {
        logic dir_in;           // pin_direction_bit, 1 = input
        logic [1:0] duty_lo;    // duty_low_bits
        logic [3:0] mode;       // mode_select_field
    } ccpu_ctrl_t;

    // pwm engine state
    typedef struct packed {
        logic [1:0] fine;
        logic [3:0] pcnt;
        logic [7:0] tb;
        logic [9:0] duty0;
        logic [9:0] duty1;
        logic [1:0] out;
        logic period;
    } ccpu_pwm_st_t;

    // compare timebase state
    typedef struct packed {
        logic [15:0] count;
        logic ovf;
    } ccpu_tb_st_t;
endpackage

// *** verilog/ccpu_pwm.sv ***
// shared pwm timebase with two duty channels
`timescale 1ns/1ps
`default_nettype none
module ccpu_pwm import ccpu_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic on_i,
    input wire logic freeze_i,
    input wire logic [7:0] period_i,
    input wire logic [1:0] presc_i,
    input wire logic [9:0] duty0_i,
    input wire logic [9:0] duty1_i,
    output logic [1:0] pwm_o,
    output logic period_o,          // one-cycle pulse at restart
    output logic [7:0] tb_o
);
    ccpu_pwm_st_t st_q, st_d;
    logic [3:0] plim;
    logic step;
    logic [9:0] ext;
    logic [9:0] top;
    logic [9:0] nxt;                // extended count after this edge

    // prescale limit decode
    always_comb begin
        case (presc_i)
            2'h0: plim = CCPU_PS1;
            2'h1: plim = CCPU_PS4;
            default: plim = CCPU_PS16;
        endcase
    end

    assign step = (st_q.fine == 2'h3) && (st_q.pcnt == plim);
    assign ext = {st_q.tb, st_q.fine};
    assign top = {period_i, 2'h3};
    // fall decided one edge early, so duty n gives n cycles high at prescale 1
    assign nxt = ext + 10'h001;

    // next state
    always_comb begin
        st_d = st_q;
        st_d.period = 1'b0;
        if (freeze_i || !on_i) begin
            st_d.period = 1'b0;
        end else begin
            st_d.fine = st_q.fine + 2'h1;
            if (st_q.fine == 2'h3) begin
                st_d.pcnt = (st_q.pcnt == plim) ? 4'h0 : st_q.pcnt + 4'h1;
            end
            if (nxt == st_q.duty0 && st_q.duty0 <= top) begin
                st_d.out[0] = 1'b0;
            end
            if (nxt == st_q.duty1 && st_q.duty1 <= top) begin
                st_d.out[1] = 1'b0;
            end
            if (step) begin
                if (st_q.tb == period_i) begin
                    st_d.tb = 8'h00;
                    st_d.period = 1'b1;
                    st_d.duty0 = duty0_i;
                    st_d.duty1 = duty1_i;
                    if (duty0_i <= top) begin
                        st_d.out[0] = (duty0_i != 10'h000);
                    end
                    if (duty1_i <= top) begin
                        st_d.out[1] = (duty1_i != 10'h000);
                    end
                end else begin
                    st_d.tb = st_q.tb + 8'h01;
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pwm_o = st_q.out;
    assign period_o = st_q.period;
    assign tb_o = st_q.tb;
endmodule
`default_nettype wire

// *** verilog/ccpu_top.sv ***
// compare and pwm unit with axi4-lite register slave
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ccpu_top import ccpu_pkg::*; #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // asynchronous inputs
    input wire logic tb_clk_i,      // timebase clock source
    input wire logic sleep_i,       // device asleep
    input wire logic adc_en_i,      // adc enabled
    // outputs
    output logic [1:0] module_pin_o,
    output logic [1:0] module_pin_oe_n_o,
    output logic [1:0] special_trig_o,
    output logic adc_start_o
);
    // whole top-level state
    typedef struct packed {
        logic [2:0] sync_tb;        // [0] first stage, [2] edge history
        logic [1:0] sync_sl;
        logic [1:0] sync_adc;
        ccpu_ctrl_t ctrl0;
        ccpu_ctrl_t ctrl1;
        logic [15:0] cmp0;
        logic [15:0] cmp1;
        logic [7:0] duty0;
        logic [7:0] duty1;
        logic [7:0] period;
        logic [1:0] presc;
        logic tb_on;
        logic [3:0] flags;
        logic [1:0] latch;          // compare output latches
        logic [1:0] match_q;
        logic [1:0] pend;           // special reset waiting for tick
        logic [1:0] trig;
        logic adc_go;
        logic [1:0] pin;
        logic [1:0] oe_n;
        logic aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ccpu_top_st_t;

    ccpu_top_st_t st_q, st_d;

    logic tb_tick, asleep;
    logic [15:0] tb_count;
    logic tb_ovf;
    logic tb_clear;
    logic tb_wr;
    logic [1:0] pwm_out;
    logic pwm_period;
    logic [7:0] pwm_tb;
    logic [1:0] match;
    logic [1:0] match_rise;

    // compare mode test
    function automatic logic is_cmp(input logic [3:0] m);
        is_cmp = (m == CCPU_M_TOGGLE) || (m == CCPU_M_SET) || (m == CCPU_M_CLEAR)
            || (m == CCPU_M_SWI) || (m == CCPU_M_SPECIAL);
    endfunction

    function automatic logic is_pwm(input logic [3:0] m);
        is_pwm = (m[3:2] == CCPU_M_PWM_TOP);
    endfunction

    // modes in which the module owns the pin
    function automatic logic owns_pin(input logic [3:0] m);
        owns_pin = is_pwm(m) || (m == CCPU_M_TOGGLE) || (m == CCPU_M_SET) || (m == CCPU_M_CLEAR);
    endfunction

    function automatic logic [9:0] duty_of(input logic [7:0] hi, input ccpu_ctrl_t c);
        duty_of = {hi, c.duty_lo};
    endfunction

    function automatic logic [3:0] res_bits(input logic [7:0] p);
        logic [8:0] n;
        logic [3:0] r;
        n = {1'b0, p} + 9'h001;
        r = 4'h2;
        for (int i = 1; i < 9; i++) begin
            if (n[i]) begin
                r = 4'(i + CCPU_PWM_EXT);
            end
        end
        res_bits = r;
    endfunction

    // byte-lane merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        merge = r;
    endfunction

    // synchronised views; first stages read only by second stages
    assign tb_tick = st_q.sync_tb[1] & ~st_q.sync_tb[2];
    assign asleep = st_q.sync_sl[1];

    assign match[0] = is_cmp(st_q.ctrl0.mode) && (tb_count == st_q.cmp0);
    assign match[1] = is_cmp(st_q.ctrl1.mode) && (tb_count == st_q.cmp1);
    assign match_rise = match & ~st_q.match_q;

    // reset only if match still holds
    assign tb_clear = |(st_q.pend & match);
    assign tb_wr = st_q.aw_full && st_q.w_full && !st_q.bvalid && (st_q.aw_addr == ADDR_W'(CCPU_TBASE));

    ccpu_cmp_timebase u_tb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tb_tick),
        .freeze_i(asleep),
        .clear_i(tb_clear),
        .wr_i(tb_wr),
        .wr_data_i(st_q.w_data[15:0]),
        .count_o(tb_count),
        .ovf_o(tb_ovf)
    );

    ccpu_pwm u_pwm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .on_i(st_q.tb_on),
        .freeze_i(asleep),
        .period_i(st_q.period),
        .presc_i(st_q.presc),
        .duty0_i(duty_of(st_q.duty0, st_q.ctrl0)),
        .duty1_i(duty_of(st_q.duty1, st_q.ctrl1)),
        .pwm_o(pwm_out),
        .period_o(pwm_period),
        .tb_o(pwm_tb)
    );

    // next state: synchronisers, compare actions, bus slave
    always_comb begin
        logic [31:0] wv;
        logic [ADDR_W-1:0] ra;
        ccpu_ctrl_t c [2];
        logic [3:0] clr;
        logic [3:0] setf;
        wv = '0;
        ra = '0;
        clr = '0;
        setf = '0;
        c[0] = st_q.ctrl0;
        c[1] = st_q.ctrl1;
        st_d = st_q;
        st_d.sync_tb = {st_q.sync_tb[1:0], tb_clk_i};
        st_d.sync_sl = {st_q.sync_sl[0], sleep_i};
        st_d.sync_adc = {st_q.sync_adc[0], adc_en_i};
        st_d.trig = '0;
        st_d.adc_go = 1'b0;

        if (!asleep) begin
            st_d.match_q = match;
            for (int k = 0; k < 2; k++) begin
                if (match_rise[k]) begin
                    setf[k] = 1'b1;
                    case (c[k].mode)
                        CCPU_M_TOGGLE: st_d.latch[k] = ~st_q.latch[k];
                        CCPU_M_SET: st_d.latch[k] = 1'b1;
                        CCPU_M_CLEAR: st_d.latch[k] = 1'b0;
                        CCPU_M_SWI: st_d.latch[k] = st_q.latch[k];
                        CCPU_M_SPECIAL: begin
                            st_d.trig[k] = 1'b1;
                            st_d.pend[k] = 1'b1;
                            if (k == 1) begin
                                st_d.adc_go = st_q.sync_adc[1];
                            end
                        end
                        default: st_d.latch[k] = st_q.latch[k];
                    endcase
                end
            end
            // pending resets resolve at the next timebase tick
            if (tb_tick) begin
                st_d.pend = '0;
            end
        end
        setf[CCPU_F_PERIOD] = pwm_period;
        setf[CCPU_F_OVF] = tb_ovf;

        for (int k = 0; k < 2; k++) begin
            st_d.oe_n[k] = c[k].dir_in || !owns_pin(c[k].mode);
            st_d.pin[k] = is_pwm(c[k].mode) ? pwm_out[k] : st_q.latch[k];
        end

        // write address and data channels, in either order
        if (s_axi_awvalid_i && st_q.awready) begin
            st_d.aw_full = 1'b1;
            st_d.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && st_q.wready) begin
            st_d.w_full = 1'b1;
            st_d.w_data = s_axi_wdata_i;
            st_d.w_strb = s_axi_wstrb_i;
        end
        if (st_q.bvalid && s_axi_bready_i) begin
            st_d.bvalid = 1'b0;
        end
        if (st_q.aw_full && st_q.w_full && !st_q.bvalid) begin
            st_d.aw_full = 1'b0;
            st_d.w_full = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = CCPU_RESP_OK;
            case (st_q.aw_addr)
                ADDR_W'(CCPU_CTRL0): begin
                    wv = merge(32'(st_q.ctrl0), st_q.w_data, st_q.w_strb);
                    st_d.ctrl0 = ccpu_ctrl_t'(wv[6:0]);
                    st_d.latch[0] = (wv[3:0] == CCPU_M_CLEAR);
                end
                ADDR_W'(CCPU_CTRL1): begin
                    wv = merge(32'(st_q.ctrl1), st_q.w_data, st_q.w_strb);
                    st_d.ctrl1 = ccpu_ctrl_t'(wv[6:0]);
                    st_d.latch[1] = (wv[3:0] == CCPU_M_CLEAR);
                end
                ADDR_W'(CCPU_CMP0): begin
                    wv = merge(32'(st_q.cmp0), st_q.w_data, st_q.w_strb);
                    st_d.cmp0 = wv[15:0];
                end
                ADDR_W'(CCPU_CMP1): begin
                    wv = merge(32'(st_q.cmp1), st_q.w_data, st_q.w_strb);
                    st_d.cmp1 = wv[15:0];
                end
                ADDR_W'(CCPU_DUTY0): begin
                    wv = merge(32'(st_q.duty0), st_q.w_data, st_q.w_strb);
                    st_d.duty0 = wv[7:0];
                end
                ADDR_W'(CCPU_DUTY1): begin
                    wv = merge(32'(st_q.duty1), st_q.w_data, st_q.w_strb);
                    st_d.duty1 = wv[7:0];
                end
                ADDR_W'(CCPU_TBASE): begin
                    wv = '0;                // load handled by the timebase
                end
                ADDR_W'(CCPU_PWMCFG): begin
                    wv = merge({21'h0, st_q.tb_on, st_q.presc, st_q.period}, st_q.w_data, st_q.w_strb);
                    st_d.period = wv[7:0];
                    st_d.presc = wv[CCPU_PC_PRESC +: 2];
                    st_d.tb_on = wv[CCPU_PC_ON];
                end
                ADDR_W'(CCPU_FLAGS): begin
                    // write one to clear
                    clr = st_q.w_strb[0] ? st_q.w_data[3:0] : 4'h0;
                end
                ADDR_W'(CCPU_PWMTB), ADDR_W'(CCPU_STATUS): begin
                    wv = '0;                // read-only, write ignored
                end
                default: st_d.bresp = CCPU_RESP_SLVERR;
            endcase
        end
        // set beats clear on the same cycle
        st_d.flags = (st_q.flags & ~clr) | setf;
        st_d.awready = !st_d.aw_full && !st_d.bvalid;
        st_d.wready = !st_d.w_full && !st_d.bvalid;

        // read channel: one word in flight
        if (st_q.rvalid && s_axi_rready_i) begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && st_q.arready) begin
            ra = s_axi_araddr_i;
            st_d.rvalid = 1'b1;
            st_d.rresp = CCPU_RESP_OK;
            case (ra)
                ADDR_W'(CCPU_CTRL0): st_d.rdata = 32'(st_q.ctrl0);
                ADDR_W'(CCPU_CTRL1): st_d.rdata = 32'(st_q.ctrl1);
                ADDR_W'(CCPU_CMP0): st_d.rdata = 32'(st_q.cmp0);
                ADDR_W'(CCPU_CMP1): st_d.rdata = 32'(st_q.cmp1);
                ADDR_W'(CCPU_DUTY0): st_d.rdata = 32'(st_q.duty0);
                ADDR_W'(CCPU_DUTY1): st_d.rdata = 32'(st_q.duty1);
                ADDR_W'(CCPU_TBASE): st_d.rdata = 32'(tb_count);
                ADDR_W'(CCPU_PWMCFG): st_d.rdata = {21'h0, st_q.tb_on, st_q.presc, st_q.period};
                ADDR_W'(CCPU_PWMTB): st_d.rdata = 32'(pwm_tb);
                ADDR_W'(CCPU_FLAGS): st_d.rdata = 32'(st_q.flags);
                ADDR_W'(CCPU_STATUS): st_d.rdata = {20'h0, res_bits(st_q.period), st_q.latch, st_q.pin,
                                                    st_q.oe_n, asleep, st_q.sync_adc[1]};
                default: begin
                    st_d.rdata = '0;
                    st_d.rresp = CCPU_RESP_SLVERR;
                end
            endcase
        end
        st_d.arready = !st_d.rvalid;
    end

    // state register; reset puts pins to input
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
            st_q.ctrl0.dir_in <= 1'b1;
            st_q.ctrl1.dir_in <= 1'b1;
            st_q.oe_n <= 2'h3;
            st_q.period <= CCPU_PERIOD_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign s_axi_awready_o = st_q.awready;
    assign s_axi_wready_o = st_q.wready;
    assign s_axi_bresp_o = st_q.bresp;
    assign s_axi_bvalid_o = st_q.bvalid;
    assign s_axi_arready_o = st_q.arready;
    assign s_axi_rdata_o = st_q.rdata;
    assign s_axi_rresp_o = st_q.rresp;
    assign s_axi_rvalid_o = st_q.rvalid;
    assign module_pin_o = st_q.pin;
    assign module_pin_oe_n_o = st_q.oe_n;
    assign special_trig_o = st_q.trig;
    assign adc_start_o = st_q.adc_go;
endmodule
`default_nettype wire
